// ===== ufc_defs.svh
// Register offsets, field positions, reset values and counts for FIFO control
`ifndef UFC_DEFS_SVH
`define UFC_DEFS_SVH

`define UFC_OFF_TX_PURGE    12'h040
`define UFC_OFF_TX_FILL     12'h041
`define UFC_OFF_TX_FORMAT   12'h042
`define UFC_OFF_RX_PURGE    12'h043
`define UFC_OFF_RX_FILL     12'h044
`define UFC_OFF_RX_FORMAT   12'h045
`define UFC_OFF_FWD_CTRL    12'h046
`define UFC_OFF_FLOW_LEVEL  12'h047
`define UFC_OFF_DRV_SELECT  12'h060

`define UFC_BIT_PURGE_NOW   0
`define UFC_BIT_AUTO_OPEN   1
`define UFC_BIT_AUTO_CLOSE  2
`define UFC_BIT_ENABLE      0

`define UFC_RST_AUTO_OPEN   1'b1
`define UFC_RST_AUTO_CLOSE  1'b0
`define UFC_RST_FLOW_LEVEL  10'h1c2

`define UFC_PKT_CUSTOM      10'h040
`define UFC_PKT_CDC         10'h03f
`define UFC_SLOW_BAUD       24'h00a000
`define UFC_WAIT_CHARS      2'h3

`endif

// ===== ufc_pkg.sv
// Types shared by the FIFO control block
package ufc_pkg;

	// Auto flush settings of one direction
	typedef struct packed {
		logic auto_close;
		logic auto_open;
	} ufc_purge_s;

	// Bulk-in forwarding state
	typedef enum logic [0:0] {
		UFC_FWD_IDLE,
		UFC_FWD_WAIT
	} ufc_fwd_e;

endpackage

// ===== ufc_ctrl.sv
// UART transmit and receive FIFO flush, fill count and forwarding control
//
// Contract
// - Transmit purge bit zero empties FIFO, self-clears
// - Auto-close flushes transmit FIFO on disable
// - Auto-open flushes transmit FIFO on enable
// - Receive purge bit zero empties FIFO, self-clears
// - Auto-close flushes receive FIFO on disable
// - Auto-open flushes receive FIFO on enable
// - Transmit fill field shows bytes held
// - Receive fill field shows bytes held
// - Transmit format bit selects wide mode
// - Receive format bit selects wide mode
// - Without low latency, wait packet or three chars
// - Standard driver uses 63-byte packet size
// - Low latency forwards at once on request
// - Standard driver, slow baud sets low latency
// - Flow control when receive fill reaches level
// - Driver select bit: custom one, standard zero
//
// The implementer's own choice: the strobed register port.

`include "ufc_defs.svh"

// ****************************************
// Byte FIFO with flush and fill count
// ****************************************
module ufc_fifo #(
	parameter int DEPTH = 512,
	parameter int WIDTH = 8
) (
	input  wire logic             i_clk,
	input  wire logic             i_reset_n,
	input  wire logic             i_flush,
	input  wire logic             i_wr_valid,
	input  wire logic [WIDTH-1:0] i_wr_data,
	output logic                  o_wr_ready,
	input  wire logic             i_rd_ready,
	output logic                  o_rd_valid,
	output logic      [WIDTH-1:0] o_rd_data,
	output logic      [9:0]       o_count
);
	localparam int AW = $clog2(DEPTH);

	// Refuse depths that the pointers and the 10-bit count cannot serve
	if (DEPTH < 2 || DEPTH > 512 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_check
		$error("ufc_fifo: DEPTH must be a power of two from 2 to 512");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [AW-1:0]    rd_ptr_next;
	logic [9:0]       count_next;
	logic             push;
	logic             pop;

	assign push = i_wr_valid && o_wr_ready && !i_flush;
	assign pop  = i_rd_ready && o_rd_valid && !i_flush;
	assign rd_ptr_next = pop ? rd_ptr_reg + AW'(1) : rd_ptr_reg;

	always_comb begin
		count_next = o_count;
		if (i_flush) begin
			count_next = 10'h000;
		end else if (push && !pop) begin
			count_next = o_count + 10'h001;
		end else if (pop && !push) begin
			count_next = o_count - 10'h001;
		end
	end

	// Storage
	always_ff @(posedge i_clk) begin
		if (push) begin
			mem[wr_ptr_reg] <= i_wr_data;
		end
	end

	// Pointers and fill count, capped at DEPTH by the ready flag
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			o_count    <= 10'h000;
			o_wr_ready <= 1'b1;
			o_rd_valid <= 1'b0;
		end else begin
			wr_ptr_reg <= i_flush ? '0 : (push ? wr_ptr_reg + AW'(1) : wr_ptr_reg);
			rd_ptr_reg <= i_flush ? '0 : rd_ptr_next;
			o_count    <= count_next;
			o_wr_ready <= count_next < 10'(DEPTH);
			o_rd_valid <= count_next != 10'h000;
		end
	end

	// Head word, bypassing a write that lands on the new head
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_rd_data <= '0;
		end else if (push && wr_ptr_reg == rd_ptr_next) begin
			o_rd_data <= i_wr_data;
		end else begin
			o_rd_data <= mem[rd_ptr_next];
		end
	end
endmodule

// ****************************************
// FIFO control top
// ****************************************
module ufc_ctrl #(
	parameter int DEPTH = 512
) (
	input  wire logic        i_clk,
	input  wire logic        i_reset_n,
	input  wire logic [11:0] i_addr,
	input  wire logic [15:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [15:0] o_rdata,
	input  wire logic        i_tx_port_en,
	input  wire logic        i_rx_port_en,
	input  wire logic        i_tx_in_valid,
	input  wire logic [7:0]  i_tx_in_data,
	output logic             o_tx_in_ready,
	input  wire logic        i_tx_out_ready,
	output logic             o_tx_out_valid,
	output logic      [7:0]  o_tx_out_data,
	input  wire logic        i_rx_in_valid,
	input  wire logic [7:0]  i_rx_in_data,
	output logic             o_rx_in_ready,
	input  wire logic        i_rx_out_ready,
	output logic             o_rx_out_valid,
	output logic      [7:0]  o_rx_out_data,
	output logic             o_tx_wide,
	output logic             o_rx_wide,
	output logic             o_custom_driver,
	output logic             o_low_latency,
	input  wire logic        i_flow_en,
	output logic             o_flow_assert,
	input  wire logic [23:0] i_baud_rate,
	input  wire logic [15:0] i_char_cycles,
	input  wire logic        i_bulk_in_req,
	output logic             o_fwd_start,
	output logic      [9:0]  o_fwd_len
);

	// Flush wanted on an enable edge, per auto settings
	function automatic logic auto_flush(input logic prev, input logic cur,
		input ufc_pkg::ufc_purge_s cfg);
		auto_flush = (cur && !prev && cfg.auto_open) || (!cur && prev && cfg.auto_close);
	endfunction

	function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
		hit = a == off;
	endfunction

	// Forward length, never above the packet size
	function automatic logic [9:0] fwd_size(input logic [9:0] cnt, input logic [9:0] lim);
		fwd_size = (cnt < lim) ? cnt : lim;
	endfunction

	ufc_pkg::ufc_purge_s tx_cfg_reg;
	ufc_pkg::ufc_purge_s rx_cfg_reg;
	ufc_pkg::ufc_fwd_e   fwd_reg;
	logic                tx_purge_reg;
	logic                rx_purge_reg;
	logic                tx_en_prev_reg;
	logic                rx_en_prev_reg;
	logic                tx_flush;
	logic                rx_flush;
	logic [9:0]          flow_level_reg;
	logic [9:0]          tx_count;
	logic [9:0]          rx_count;
	logic [9:0]          max_pkt;
	logic [15:0]         cyc_reg;
	logic [1:0]          chars_reg;
	logic [9:0]          rx_count_prev_reg;

	// ****************************************
	// Flush sources
	// ****************************************
	assign tx_flush = tx_purge_reg || auto_flush(tx_en_prev_reg, i_tx_port_en, tx_cfg_reg);
	assign rx_flush = rx_purge_reg || auto_flush(rx_en_prev_reg, i_rx_port_en, rx_cfg_reg);

	// Port enable history for edge detection
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			tx_en_prev_reg <= 1'b0;
			rx_en_prev_reg <= 1'b0;
		end else begin
			tx_en_prev_reg <= i_tx_port_en;
			rx_en_prev_reg <= i_rx_port_en;
		end
	end

	// Purge registers: settings kept, purge bit a one-cycle pulse
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			tx_cfg_reg   <= '{auto_close: `UFC_RST_AUTO_CLOSE, auto_open: `UFC_RST_AUTO_OPEN};
			rx_cfg_reg   <= '{auto_close: `UFC_RST_AUTO_CLOSE, auto_open: `UFC_RST_AUTO_OPEN};
			tx_purge_reg <= 1'b0;
			rx_purge_reg <= 1'b0;
		end else begin
			tx_purge_reg <= i_wr && hit(i_addr, `UFC_OFF_TX_PURGE)
				&& i_wdata[`UFC_BIT_PURGE_NOW];
			rx_purge_reg <= i_wr && hit(i_addr, `UFC_OFF_RX_PURGE)
				&& i_wdata[`UFC_BIT_PURGE_NOW];
			if (i_wr && hit(i_addr, `UFC_OFF_TX_PURGE)) begin
				tx_cfg_reg.auto_close <= i_wdata[`UFC_BIT_AUTO_CLOSE];
				tx_cfg_reg.auto_open  <= i_wdata[`UFC_BIT_AUTO_OPEN];
			end
			if (i_wr && hit(i_addr, `UFC_OFF_RX_PURGE)) begin
				rx_cfg_reg.auto_close <= i_wdata[`UFC_BIT_AUTO_CLOSE];
				rx_cfg_reg.auto_open  <= i_wdata[`UFC_BIT_AUTO_OPEN];
			end
		end
	end

	// ****************************************
	// FIFOs
	// ****************************************
	ufc_fifo #(.DEPTH(DEPTH), .WIDTH(8)) u_tx_fifo (
		.i_clk      (i_clk),
		.i_reset_n  (i_reset_n),
		.i_flush    (tx_flush),
		.i_wr_valid (i_tx_in_valid),
		.i_wr_data  (i_tx_in_data),
		.o_wr_ready (o_tx_in_ready),
		.i_rd_ready (i_tx_out_ready),
		.o_rd_valid (o_tx_out_valid),
		.o_rd_data  (o_tx_out_data),
		.o_count    (tx_count)
	);

	ufc_fifo #(.DEPTH(DEPTH), .WIDTH(8)) u_rx_fifo (
		.i_clk      (i_clk),
		.i_reset_n  (i_reset_n),
		.i_flush    (rx_flush),
		.i_wr_valid (i_rx_in_valid),
		.i_wr_data  (i_rx_in_data),
		.o_wr_ready (o_rx_in_ready),
		.i_rd_ready (i_rx_out_ready),
		.o_rd_valid (o_rx_out_valid),
		.o_rd_data  (o_rx_out_data),
		.o_count    (rx_count)
	);

	// ****************************************
	// Mode registers
	// ****************************************
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_tx_wide       <= 1'b0;
			o_rx_wide       <= 1'b0;
			o_custom_driver <= 1'b0;
			flow_level_reg  <= `UFC_RST_FLOW_LEVEL;
		end else if (i_wr) begin
			if (hit(i_addr, `UFC_OFF_TX_FORMAT))
				o_tx_wide <= i_wdata[`UFC_BIT_ENABLE];
			if (hit(i_addr, `UFC_OFF_RX_FORMAT))
				o_rx_wide <= i_wdata[`UFC_BIT_ENABLE];
			if (hit(i_addr, `UFC_OFF_DRV_SELECT))
				o_custom_driver <= i_wdata[`UFC_BIT_ENABLE];
			if (hit(i_addr, `UFC_OFF_FLOW_LEVEL))
				flow_level_reg <= i_wdata[9:0];
		end
	end

	// Low latency: hardware set beats a software clear
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_low_latency <= 1'b0;
		end else if (!o_custom_driver && i_baud_rate < `UFC_SLOW_BAUD) begin
			o_low_latency <= 1'b1;
		end else if (i_wr && hit(i_addr, `UFC_OFF_FWD_CTRL)) begin
			o_low_latency <= i_wdata[`UFC_BIT_ENABLE];
		end
	end

	// Flow control request from receive fill level
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_flow_assert <= 1'b0;
		end else begin
			o_flow_assert <= i_flow_en && rx_count >= flow_level_reg;
		end
	end

	// ****************************************
	// Register read port
	// ****************************************
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_rdata <= 16'h0000;
		end else if (i_rd) begin
			case (i_addr)
				`UFC_OFF_TX_FILL:    o_rdata <= {6'h00, tx_count};
				`UFC_OFF_RX_FILL:    o_rdata <= {6'h00, rx_count};
				`UFC_OFF_TX_FORMAT:  o_rdata <= {15'h0000, o_tx_wide};
				`UFC_OFF_RX_FORMAT:  o_rdata <= {15'h0000, o_rx_wide};
				`UFC_OFF_FWD_CTRL:   o_rdata <= {15'h0000, o_low_latency};
				`UFC_OFF_FLOW_LEVEL: o_rdata <= {6'h00, flow_level_reg};
				default:             o_rdata <= 16'h0000;
			endcase
		end else begin
			o_rdata <= 16'h0000;
		end
	end

	// ****************************************
	// Bulk-in forwarding
	// ****************************************
	assign max_pkt = o_custom_driver ? `UFC_PKT_CUSTOM : `UFC_PKT_CDC;

	// Receive fill one cycle back, to spot new bytes
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rx_count_prev_reg <= 10'h000;
		end else begin
			rx_count_prev_reg <= rx_count;
		end
	end

	// Character timer, restarted by request or new receive byte
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			cyc_reg   <= 16'h0000;
			chars_reg <= 2'h0;
		end else if (fwd_reg == ufc_pkg::UFC_FWD_IDLE || rx_count > rx_count_prev_reg) begin
			cyc_reg   <= 16'h0000;
			chars_reg <= 2'h0;
		end else if (cyc_reg + 16'h0001 >= i_char_cycles) begin
			cyc_reg <= 16'h0000;
			if (chars_reg != `UFC_WAIT_CHARS)
				chars_reg <= chars_reg + 2'h1;
		end else begin
			cyc_reg <= cyc_reg + 16'h0001;
		end
	end

	// Forwarding state machine
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			fwd_reg     <= ufc_pkg::UFC_FWD_IDLE;
			o_fwd_start <= 1'b0;
			o_fwd_len   <= 10'h000;
		end else begin
			o_fwd_start <= 1'b0;
			case (fwd_reg)
				ufc_pkg::UFC_FWD_IDLE: begin
					if (i_bulk_in_req && o_low_latency) begin
						o_fwd_start <= 1'b1;
						o_fwd_len   <= fwd_size(rx_count, max_pkt);
					end else if (i_bulk_in_req) begin
						fwd_reg <= ufc_pkg::UFC_FWD_WAIT;
					end
				end
				ufc_pkg::UFC_FWD_WAIT: begin
					if (o_low_latency || rx_count >= max_pkt
						|| chars_reg == `UFC_WAIT_CHARS) begin
						fwd_reg     <= ufc_pkg::UFC_FWD_IDLE;
						o_fwd_start <= 1'b1;
						o_fwd_len   <= fwd_size(rx_count, max_pkt);
					end
				end
				default: begin
					fwd_reg <= ufc_pkg::UFC_FWD_IDLE;
				end
			endcase
		end
	end

endmodule

// ===== ufc_ctrl_checker.sv
// Assertion checker for the FIFO control block
module ufc_ctrl_checker (
	input wire logic        i_clk,
	input wire logic        i_reset_n,
	input wire logic [11:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic        i_wr,
	input wire logic        i_tx_port_en,
	input wire logic        o_tx_out_valid,
	input wire logic        o_rx_out_valid,
	input wire logic        o_tx_wide,
	input wire logic        o_rx_wide,
	input wire logic        o_custom_driver,
	input wire logic        o_low_latency,
	input wire logic        i_flow_en,
	input wire logic        o_flow_assert,
	input wire logic [23:0] i_baud_rate,
	input wire logic        i_bulk_in_req,
	input wire logic        o_fwd_start
);
	timeunit 1ns;
	timeprecision 1ps;
	ufc_pkg::ufc_purge_s tx_cfg_reg;
	// Mirror of the transmit auto flush flags
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			tx_cfg_reg <= 2'h1;
		end else if (i_wr && i_addr == 12'h040) begin
			tx_cfg_reg <= i_wdata[2:1];
		end
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);
	property p_tx_purge;
		i_wr && i_addr == 12'h040 && i_wdata[0] |-> ##2 !o_tx_out_valid;
	endproperty
	a_tx_purge: assert property (p_tx_purge) else $error("tx purge kept data");
	property p_rx_purge;
		i_wr && i_addr == 12'h043 && i_wdata[0] |-> ##2 !o_rx_out_valid;
	endproperty
	a_rx_purge: assert property (p_rx_purge) else $error("rx purge kept data");
	property p_tx_open;
		$rose(i_tx_port_en) && tx_cfg_reg.auto_open |-> ##[1:2] !o_tx_out_valid;
	endproperty
	a_tx_open: assert property (p_tx_open) else $error("no flush on enable");
	property p_tx_close;
		$fell(i_tx_port_en) && tx_cfg_reg.auto_close |-> ##[1:2] !o_tx_out_valid;
	endproperty
	a_tx_close: assert property (p_tx_close) else $error("no flush on disable");
	property p_tx_wide;
		i_wr && i_addr == 12'h042 |=> o_tx_wide == $past(i_wdata[0]);
	endproperty
	a_tx_wide: assert property (p_tx_wide) else $error("tx wide mismatch");
	property p_rx_wide;
		i_wr && i_addr == 12'h045 |=> o_rx_wide == $past(i_wdata[0]);
	endproperty
	a_rx_wide: assert property (p_rx_wide) else $error("rx wide mismatch");
	property p_drv;
		i_wr && i_addr == 12'h060 |=> o_custom_driver == $past(i_wdata[0]);
	endproperty
	a_drv: assert property (p_drv) else $error("driver select mismatch");
	property p_slow;
		!o_custom_driver && i_baud_rate < 24'h00a000 |-> ##[1:2] o_low_latency;
	endproperty
	a_slow: assert property (p_slow) else $error("low latency not set");
	property p_now;
		i_bulk_in_req && o_low_latency |=> o_fwd_start;
	endproperty
	a_now: assert property (p_now) else $error("no immediate forward");
	property p_pulse;
		o_fwd_start |=> !o_fwd_start;
	endproperty
	a_pulse: assert property (p_pulse) else $error("forward start too long");
	property p_flow;
		!i_flow_en |=> !o_flow_assert;
	endproperty
	a_flow: assert property (p_flow) else $error("flow asserted while off");
endmodule

bind ufc_ctrl ufc_ctrl_checker u_chk (
	.i_clk           (i_clk),
	.i_reset_n       (i_reset_n),
	.i_addr          (i_addr),
	.i_wdata         (i_wdata),
	.i_wr            (i_wr),
	.i_tx_port_en    (i_tx_port_en),
	.o_tx_out_valid  (o_tx_out_valid),
	.o_rx_out_valid  (o_rx_out_valid),
	.o_tx_wide       (o_tx_wide),
	.o_rx_wide       (o_rx_wide),
	.o_custom_driver (o_custom_driver),
	.o_low_latency   (o_low_latency),
	.i_flow_en       (i_flow_en),
	.o_flow_assert   (o_flow_assert),
	.i_baud_rate     (i_baud_rate),
	.i_bulk_in_req   (i_bulk_in_req),
	.o_fwd_start     (o_fwd_start)
);

// ===== ufc_host_model.sv
// Bulk-in host model that drains forwarded receive bytes
module ufc_host_model (
	input  wire logic       i_clk,
	input  wire logic       i_reset_n,
	input  wire logic       i_slow,
	input  wire logic       i_fwd_start,
	input  wire logic [9:0] i_fwd_len,
	input  wire logic       i_valid,
	input  wire logic [7:0] i_data,
	output logic            o_ready,
	output logic            o_got_v,
	output logic      [7:0] o_got
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [9:0] left_reg;
	logic       tog_reg;
	assign o_ready = (left_reg != 10'h000) && (!i_slow || tog_reg);
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			left_reg <= 10'h000;
			tog_reg <= 1'h0;
			o_got_v <= 1'h0;
			o_got <= 8'h00;
		end else begin
			tog_reg <= ~tog_reg;
			o_got_v <= o_ready && i_valid;
			o_got <= i_data;
			if (i_fwd_start) begin
				left_reg <= i_fwd_len;
			end else if (o_ready && i_valid) begin
				left_reg <= left_reg - 10'h001;
			end
		end
	end
endmodule

// ===== ufc_ctrl_tb.sv
// Self-checking bench for the FIFO control block
module ufc_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        i_clk, i_reset_n, i_wr, i_rd, i_tx_port_en, i_rx_port_en, i_flow_en;
	logic        i_tx_in_valid, i_rx_in_valid, i_tx_out_ready, i_bulk_in_req, hm_slow;
	logic        i_rx_out_ready, o_tx_out_valid, o_rx_out_valid, o_tx_wide, o_rx_wide;
	logic        o_custom_driver, o_low_latency, o_flow_assert, o_fwd_start, hm_got_v;
	logic [7:0]  i_tx_in_data, i_rx_in_data, o_tx_out_data, o_rx_out_data, hm_got;
	logic [7:0]  txq[$], rxq[$];
	logic [9:0]  o_fwd_len;
	logic [11:0] i_addr;
	logic [15:0] i_wdata, o_rdata, i_char_cycles;
	logic [23:0] i_baud_rate;
	logic [11:0] ra[10] = '{12'h040, 12'h041, 12'h042, 12'h043, 12'h044, 12'h045, 12'h046,
		12'h047, 12'h060, 12'h050};
	logic        tx_in_ready, rx_in_ready;
	int          bad_count, n_compared, seed, n;
	ufc_ctrl dut (.*, .o_tx_in_ready(tx_in_ready), .o_rx_in_ready(rx_in_ready));
	ufc_host_model u_host (.i_clk, .i_reset_n, .i_slow(hm_slow), .i_fwd_start(o_fwd_start),
		.i_fwd_len(o_fwd_len), .i_valid(o_rx_out_valid), .i_data(o_rx_out_data),
		.o_ready(i_rx_out_ready), .o_got_v(hm_got_v), .o_got(hm_got));
	initial begin
		i_clk = 1'h0;
		forever #10 i_clk = ~i_clk;
	end
	task chk(input logic [15:0] g, input logic [15:0] e);
		n_compared++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %0t got %h expected %h", $time, g, e);
		end
	endtask
	task report_and_stop;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task wr(input logic [11:0] a, input logic [15:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'h1;
		@(posedge i_clk);
		i_wr <= 1'h0;
	endtask
	task rc(input logic [11:0] a, input logic [15:0] e);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'h1;
		@(posedge i_clk);
		i_rd <= 1'h0;
		@(negedge i_clk);
		chk(o_rdata, e);
		@(posedge i_clk);
	endtask
	task push(input bit rx, input int cnt);
		logic [7:0] b;
		for (int k = 0; k < cnt; k++) begin
			@(posedge i_clk);
			b = 8'($random(seed));
			i_tx_in_valid <= !rx;
			i_rx_in_valid <= rx;
			i_tx_in_data <= b;
			i_rx_in_data <= b;
			if (rx) rxq.push_back(b);
			else txq.push_back(b);
		end
		@(posedge i_clk);
		i_tx_in_valid <= 1'h0;
		i_rx_in_valid <= 1'h0;
	endtask
	task drain(input int cnt);
		@(posedge i_clk);
		i_tx_out_ready <= 1'h1;
		repeat (cnt) begin
			@(negedge i_clk);
			chk({o_tx_out_valid, o_tx_out_data}, {1'h1, txq.pop_front()});
			@(posedge i_clk);
		end
		i_tx_out_ready <= 1'h0;
	endtask
	task wait_fwd;
		int k;
		for (k = 0; k < 4000; k++) begin
			@(negedge i_clk);
			if (o_fwd_start === 1'h1) break;
		end
		if (k == 4000) begin
			bad_count++;
			report_and_stop;
		end
	endtask
	task fwd(input int pre, input int post);
		repeat (150) @(posedge i_clk);
		wr(12'h043, 16'h0003);
		rxq.delete();
		repeat (2) @(posedge i_clk);
		push(1, pre);
		@(posedge i_clk);
		i_bulk_in_req <= 1'h1;
		@(posedge i_clk);
		i_bulk_in_req <= 1'h0;
		fork
			push(1, post);
			wait_fwd();
		join
		@(posedge i_clk);
	endtask
	always @(negedge i_clk) if (hm_got_v === 1'h1) chk(hm_got, rxq.pop_front());
	initial begin
		{i_reset_n, i_wr, i_rd, i_tx_port_en, i_rx_port_en, i_flow_en, hm_slow} = 7'h00;
		{i_tx_in_valid, i_rx_in_valid, i_tx_out_ready, i_bulk_in_req} = 4'h0;
		{i_addr, i_wdata, i_tx_in_data, i_rx_in_data} = 44'h0;
		i_baud_rate = 24'h01c200;
		i_char_cycles = 16'h03e8;
		seed = 32'h4342;
		bad_count = 0;
		n_compared = 0;
		repeat (10) @(posedge i_clk);
		i_reset_n <= 1'h1;
		foreach (ra[k]) rc(ra[k], (ra[k] == 12'h047) ? 16'h01c2 : 16'h0000);
		chk(tx_in_ready, 16'h0001);
		chk(rx_in_ready, 16'h0001);
		i_tx_port_en <= 1'h1;
		i_rx_port_en <= 1'h1;
		n = 1 + ($random(seed) & 15);
		push(0, n);
		rc(12'h041, 16'(n));
		drain(n);
		push(0, 3);
		wr(12'h040, 16'h0002);
		rc(12'h041, 16'h0003);
		wr(12'h040, 16'h0003);
		txq.delete();
		rc(12'h041, 16'h0000);
		push(1, 4);
		rc(12'h044, 16'h0004);
		wr(12'h043, 16'h0003);
		rxq.delete();
		rc(12'h044, 16'h0000);
		push(0, 2);
		wr(12'h040, 16'h0004);
		i_tx_port_en <= 1'h0;
		txq.delete();
		rc(12'h041, 16'h0000);
		push(0, 2);
		i_tx_port_en <= 1'h1;
		wr(12'h040, 16'h0002);
		i_tx_port_en <= 1'h0;
		rc(12'h041, 16'h0002);
		i_tx_port_en <= 1'h1;
		txq.delete();
		rc(12'h041, 16'h0000);
		push(1, 2);
		i_rx_port_en <= 1'h0;
		rc(12'h044, 16'h0002);
		i_rx_port_en <= 1'h1;
		rxq.delete();
		rc(12'h044, 16'h0000);
		wr(12'h043, 16'h0004);
		push(1, 2);
		i_rx_port_en <= 1'h0;
		rxq.delete();
		rc(12'h044, 16'h0000);
		push(1, 2);
		i_rx_port_en <= 1'h1;
		rc(12'h044, 16'h0002);
		wr(12'h043, 16'h0003);
		rxq.delete();
		rc(12'h044, 16'h0000);
		n = $random(seed) & 1;
		wr(12'h042, 16'(n));
		wr(12'h045, 16'(n ^ 1));
		rc(12'h042, 16'(n));
		rc(12'h045, 16'(n ^ 1));
		chk(o_tx_wide, 16'(n));
		chk(o_rx_wide, 16'(n ^ 1));
		push(0, 513);
		rc(12'h041, 16'h0200);
		chk(tx_in_ready, 16'h0000);
		wr(12'h040, 16'h0003);
		txq.delete();
		rc(12'h041, 16'h0000);
		chk(tx_in_ready, 16'h0001);
		wr(12'h046, 16'h0001);
		fwd(5, 0);
		chk(o_fwd_len, 16'h0005);
		wr(12'h046, 16'h0000);
		rc(12'h046, 16'h0000);
		hm_slow <= 1'h1;
		fwd(0, 64);
		chk(o_fwd_len, 16'h003f);
		wr(12'h060, 16'h0001);
		fwd(0, 64);
		chk(o_fwd_len, 16'h0040);
		chk(o_custom_driver, 16'h0001);
		i_char_cycles <= 16'h000a;
		fwd(0, 7);
		chk(o_fwd_len, 16'h0007);
		repeat (150) @(posedge i_clk);
		wr(12'h047, 16'h0003);
		rc(12'h047, 16'h0003);
		i_flow_en <= 1'h1;
		repeat (4) begin
			push(1, 1);
			repeat (2) @(posedge i_clk);
			@(negedge i_clk);
			chk(o_flow_assert, 16'(rxq.size() >= 3));
		end
		wr(12'h060, 16'h0000);
		i_baud_rate <= 24'h002580;
		wr(12'h046, 16'h0000);
		rc(12'h046, 16'h0001);
		report_and_stop;
	end
endmodule
